// file: include/spi_trig_pkg.sv
// Shared constants and types for the SPI bus pattern trigger.
// Assumes a 10 MHz reference clock and a bus clock that only the bus drives.
package spi_trig_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned PAT_MIN = 4;        // Shortest pattern, bits
    localparam int unsigned PAT_MAX = 96;       // Longest pattern, bits
    localparam int unsigned PAT_IDX_W = 7;      // Pattern index / length width
    localparam int unsigned WORD_MAX = 32;      // Longest decode word, bits
    localparam int unsigned DLEN_W = 6;         // Decode length width
    localparam int unsigned CNT_W = 16;         // Edge counter width
    localparam int unsigned FNUM_W = 16;        // Frame number width
    localparam int unsigned LIM_W = 24;         // Idle limit width, in clock cycles

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;              // Reference clock period
    localparam int unsigned LIMIT_MIN_NS = 100;               // Shortest idle limit
    localparam int unsigned LIMIT_MAX_NS = 1_000_000_000;     // Longest idle limit (1 s)
    localparam int unsigned LIMIT_MIN_CYC = (LIMIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LIMIT_MAX_CYC = LIMIT_MAX_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    // Per-bit pattern code
    typedef enum logic [1:0] {
        PAT_LOW = 2'h0,
        PAT_HIGH = 2'h1,
        PAT_ANY = 2'h2
    } pat_code_t;

    // One-hot decode slot holding this protocol
    localparam logic [1:0] SLOT_ONE = 2'h1;
    localparam logic [1:0] SLOT_TWO = 2'h2;
    localparam logic [1:0] SLOT_RESET = SLOT_TWO;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Configuration handed to the bus-clock domain
    typedef struct packed {
        logic [PAT_MAX-1:0] val;
        logic [PAT_MAX-1:0] care;
        logic [PAT_IDX_W-1:0] len;
        logic src_mosi;
        logic msb_first;
        logic tmo_mode;
        logic cs_high;
        logic [DLEN_W-1:0] dlen;
    } link_cfg_t;

    // Event toggles handed back to the reference domain
    typedef struct packed {
        logic [1:0] wgray;
        logic trig;
    } link_evt_t;

    // One decoded word per data line
    typedef struct packed {
        logic [WORD_MAX-1:0] miso;
        logic [WORD_MAX-1:0] mosi;
    } word_pair_t;

endpackage

// file: src/bit_sync.sv
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit changes rarely relative to the receiving clock.
`timescale 1ns/100ps
module bit_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Receiving clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Levels in and out
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta; // First stage, read only by the second

    // ------------------------------------------------------------
    // Two flip-flops per bit
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule

// file: src/spi_pattern_trigger.sv
// Passive SPI monitor: frames transfers, matches a start-of-frame pattern,
// decodes words and reports per-frame statistics.
// Assumes the bus clock only moves inside frames and the data lines and
// chip select are stable around the chosen latch edge.
`timescale 1ns/100ps
module spi_pattern_trigger #(
    parameter int unsigned IDLE_MAX_CYC = spi_trig_pkg::LIMIT_MAX_CYC
) (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    // Monitored bus, observed only
    input wire logic SPI_SCLK_I,
    input wire logic SPI_CS_I,
    input wire logic SPI_MOSI_I,
    input wire logic SPI_MISO_I,
    // Bus setup
    input wire logic LATCH_FALL_I,
    input wire logic FRAME_BY_TIMEOUT_I,
    input wire logic CS_ACTIVE_HIGH_I,
    input wire logic [spi_trig_pkg::LIM_W-1:0] IDLE_LIMIT_I,
    input wire logic IDLE_HIGH_I,
    input wire logic MSB_FIRST_I,
    // Trigger and decode setup
    input wire logic SRC_MOSI_I,
    input wire logic [spi_trig_pkg::PAT_IDX_W-1:0] PAT_LEN_I,
    input wire logic [spi_trig_pkg::DLEN_W-1:0] DEC_LEN_I,
    // Pattern programming
    input wire logic PAT_WR_I,
    input wire logic PAT_FILL_I,
    input wire logic [spi_trig_pkg::PAT_IDX_W-1:0] PAT_IDX_I,
    input wire logic [1:0] PAT_CODE_I,
    // Decode slot selection
    input wire logic SLOT_WR_I,
    input wire logic SLOT_SEL_I,
    // Trigger
    output logic TRIGGER_O,
    // Word report
    output logic WORD_VALID_O,
    output logic [spi_trig_pkg::WORD_MAX-1:0] MISO_WORD_O,
    output logic [spi_trig_pkg::WORD_MAX-1:0] MOSI_WORD_O,
    output logic [spi_trig_pkg::FNUM_W-1:0] WORD_FRAME_O,
    // Frame report
    output logic FRAME_DONE_O,
    output logic [spi_trig_pkg::FNUM_W-1:0] FRAME_NUM_O,
    output logic [spi_trig_pkg::CNT_W-1:0] EDGE_COUNT_O,
    output logic FRAME_UNKNOWN_O,
    output logic FRAME_ALIASED_O,
    // Decode slot
    output logic [1:0] SLOT_O
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Whether a pattern code compares the line at all
    function automatic logic code_care(input logic [1:0] code);
        code_care = (code == spi_trig_pkg::PAT_LOW) || (code == spi_trig_pkg::PAT_HIGH);
    endfunction

    // Level a pattern code expects
    function automatic logic code_val(input logic [1:0] code);
        code_val = (code == spi_trig_pkg::PAT_HIGH);
    endfunction

    // Gray to binary for the two-bit word counter
    function automatic logic [1:0] gray2bin(input logic [1:0] g);
        gray2bin = {g[1], g[1] ^ g[0]};
    endfunction

    // Put one received bit into a word under assembly
    function automatic logic [spi_trig_pkg::WORD_MAX-1:0] place(
        input logic [spi_trig_pkg::WORD_MAX-1:0] old,
        input logic [spi_trig_pkg::DLEN_W-1:0] pos,
        input logic b,
        input logic msb
    );
        logic [spi_trig_pkg::WORD_MAX-1:0] base;
        base = (pos == '0) ? '0 : old;
        if (msb)
        begin
            place = {base[spi_trig_pkg::WORD_MAX-2:0], b};
        end
        else
        begin
            place = base;
            place[pos[spi_trig_pkg::DLEN_W-2:0]] = b;
        end
    endfunction

    // ------------------------------------------------------------
    // Reference domain: setup registers
    // ------------------------------------------------------------
    logic [spi_trig_pkg::PAT_MAX-1:0] pat_val; // Expected levels
    logic [spi_trig_pkg::PAT_MAX-1:0] pat_care; // Compared bits
    spi_trig_pkg::link_cfg_t cfg_ref; // Setup bound for the bus domain
    logic latch_fall; // Latch on falling bus clock edge
    logic tmo_mode; // Framing by clock idle timeout
    logic cs_high; // Chip select active level
    logic idle_high; // Bus clock rests high
    logic [spi_trig_pkg::LIM_W-1:0] limit; // Clamped idle limit, cycles

    // Pattern store: fill first, else single-bit write
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            pat_val <= '0;
            pat_care <= '0;
        end
        else if (PAT_FILL_I)
        begin
            pat_val <= {spi_trig_pkg::PAT_MAX{code_val(PAT_CODE_I)}};
            pat_care <= {spi_trig_pkg::PAT_MAX{code_care(PAT_CODE_I)}};
        end
        else if (PAT_WR_I && PAT_IDX_I < spi_trig_pkg::PAT_IDX_W'(spi_trig_pkg::PAT_MAX))
        begin
            pat_val[PAT_IDX_I] <= code_val(PAT_CODE_I);
            pat_care[PAT_IDX_I] <= code_care(PAT_CODE_I);
        end
    end

    // Mode bits registered on this side; latch_fall also forms the bus-domain clock
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            latch_fall <= 1'b0;
            tmo_mode <= 1'b0;
            cs_high <= 1'b0;
            idle_high <= 1'b0;
        end
        else
        begin
            latch_fall <= LATCH_FALL_I;
            tmo_mode <= FRAME_BY_TIMEOUT_I;
            cs_high <= CS_ACTIVE_HIGH_I;
            idle_high <= IDLE_HIGH_I;
        end
    end

    // Setup word for the bus domain, lengths clamped to legal range
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            cfg_ref <= '0;
        end
        else
        begin
            cfg_ref.val <= pat_val;
            cfg_ref.care <= pat_care;
            // Pattern length held within 4..96
            if (PAT_LEN_I < spi_trig_pkg::PAT_IDX_W'(spi_trig_pkg::PAT_MIN))
                cfg_ref.len <= spi_trig_pkg::PAT_IDX_W'(spi_trig_pkg::PAT_MIN);
            else if (PAT_LEN_I > spi_trig_pkg::PAT_IDX_W'(spi_trig_pkg::PAT_MAX))
                cfg_ref.len <= spi_trig_pkg::PAT_IDX_W'(spi_trig_pkg::PAT_MAX);
            else
                cfg_ref.len <= PAT_LEN_I;
            cfg_ref.src_mosi <= SRC_MOSI_I;
            cfg_ref.msb_first <= MSB_FIRST_I;
            cfg_ref.tmo_mode <= FRAME_BY_TIMEOUT_I;
            cfg_ref.cs_high <= CS_ACTIVE_HIGH_I;
            // Decode length held within 1..32
            if (DEC_LEN_I == '0)
                cfg_ref.dlen <= spi_trig_pkg::DLEN_W'(1);
            else if (DEC_LEN_I > spi_trig_pkg::DLEN_W'(spi_trig_pkg::WORD_MAX))
                cfg_ref.dlen <= spi_trig_pkg::DLEN_W'(spi_trig_pkg::WORD_MAX);
            else
                cfg_ref.dlen <= DEC_LEN_I;
        end
    end

    // Idle limit clamp to 100 ns .. IDLE_MAX_CYC cycles (1 s by default)
    always_comb
    begin
        if (IDLE_LIMIT_I < spi_trig_pkg::LIM_W'(spi_trig_pkg::LIMIT_MIN_CYC))
            limit = spi_trig_pkg::LIM_W'(spi_trig_pkg::LIMIT_MIN_CYC);
        else if (IDLE_LIMIT_I > spi_trig_pkg::LIM_W'(IDLE_MAX_CYC))
            limit = spi_trig_pkg::LIM_W'(IDLE_MAX_CYC);
        else
            limit = IDLE_LIMIT_I;
    end

    // ------------------------------------------------------------
    // Reference domain: bus activity and framing
    // ------------------------------------------------------------
    logic [1:0] pins_s; // Synchronised {clock, select}
    logic sclk_s; // Synchronised bus clock
    logic cs_s; // Synchronised chip select
    logic sclk_prev; // Bus clock one cycle back
    logic cs_act_prev; // Select was active one cycle back
    logic [spi_trig_pkg::LIM_W-1:0] idle_cnt; // Cycles of quiet clock
    logic tmo_fire; // Idle limit reached, one cycle
    logic moved; // Clock moved since last frame end
    logic end_evt; // Frame has just ended
    logic link_rst_n; // Frame-start clear for the bus domain

    bit_sync #(.WIDTH(2)) u_pin_sync (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESET_N_I),
        .d_i({SPI_SCLK_I, SPI_CS_I}),
        .q_o(pins_s)
    );
    assign sclk_s = pins_s[1];
    assign cs_s = pins_s[0];

    // Quiet-clock counter; only counts while resting at the idle level
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            sclk_prev <= 1'b0;
            idle_cnt <= '0;
            tmo_fire <= 1'b0;
        end
        else
        begin
            sclk_prev <= sclk_s;
            if (sclk_s != sclk_prev || sclk_s != idle_high)
                idle_cnt <= '0;
            else if (idle_cnt != limit)
                idle_cnt <= idle_cnt + 1'b1;
            // Single pulse as the quiet time reaches the limit
            tmo_fire <= tmo_mode && sclk_s == sclk_prev && sclk_s == idle_high
                        && idle_cnt == limit - 1'b1;
        end
    end

    // Bus-domain frame clear: idle timeout pulse, or inactive select level.
    // The select path is raw so the first edge after assertion is not lost.
    assign link_rst_n = RESET_N_I & ~tmo_fire & ~(~tmo_mode & (SPI_CS_I ^ cs_high));

    // Frame end detection and activity tracking
    assign end_evt = tmo_mode ? tmo_fire : (cs_act_prev && cs_s != cs_high);

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            cs_act_prev <= 1'b0;
            moved <= 1'b0;
        end
        else
        begin
            cs_act_prev <= (cs_s == cs_high);
            // A clock change in the end cycle still counts as activity
            if (sclk_s != sclk_prev)
                moved <= 1'b1;
            else if (end_evt)
                moved <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Bus domain: sampling, pattern match, word assembly
    // ------------------------------------------------------------
    logic link_clk; // Latch edge appears as a rising edge
    spi_trig_pkg::link_cfg_t cfg_l; // Setup seen by the bus domain
    logic fresh; // Next edge is bit zero of a frame
    logic in_frame; // Edge belongs to a frame
    logic sbit; // Pattern source line level
    logic [spi_trig_pkg::PAT_IDX_W-1:0] pos; // Bit position after last edge
    logic [spi_trig_pkg::PAT_IDX_W-1:0] k; // Position of this edge
    logic [spi_trig_pkg::PAT_IDX_W-1:0] idx; // Pattern bit compared now
    logic hit; // This bit agrees with the pattern
    logic ok_now; // Pattern agrees up to this bit
    logic match_ok; // Pattern agreed so far
    logic trig_tog; // Toggles on every match
    logic [spi_trig_pkg::CNT_W-1:0] edge_cnt; // Latch edges in this frame
    logic [spi_trig_pkg::DLEN_W-1:0] wbit; // Bit position in word after last edge
    logic [spi_trig_pkg::DLEN_W-1:0] wp; // Bit position in word for this edge
    logic wdone; // This edge completes a word
    logic [spi_trig_pkg::WORD_MAX-1:0] sh_miso; // MISO word under assembly
    logic [spi_trig_pkg::WORD_MAX-1:0] sh_mosi; // MOSI word under assembly
    spi_trig_pkg::word_pair_t word_l; // Last completed word pair
    logic [1:0] wcnt; // Completed words, binary
    logic [1:0] wgray_l; // Completed words, gray coded for the crossing
    spi_trig_pkg::link_evt_t evt_l; // Toggles for the reference domain
    logic partial; // A word is only partly received

    assign link_clk = SPI_SCLK_I ^ latch_fall;

    bit_sync #(.WIDTH($bits(spi_trig_pkg::link_cfg_t))) u_cfg_sync (
        .clk_i(link_clk),
        .rst_n_i(RESET_N_I),
        .d_i(cfg_ref),
        .q_o(cfg_l)
    );

    // Frame start marker, set by the frame clear
    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            fresh <= 1'b1;
        else
            fresh <= 1'b0;
    end

    // Per-edge decode of position and pattern agreement
    always_comb
    begin
        in_frame = cfg_l.tmo_mode | (SPI_CS_I == cfg_l.cs_high);
        sbit = cfg_l.src_mosi ? SPI_MOSI_I : SPI_MISO_I;
        k = fresh ? '0 : pos;
        idx = cfg_l.msb_first ? PAT_IDX_W_SUB(cfg_l.len, k) : k;
        hit = !cfg_l.care[idx] || (cfg_l.val[idx] == sbit);
        ok_now = ((k == '0) || match_ok) && hit;
        wp = fresh ? '0 : wbit;
        wdone = (wp == cfg_l.dlen - 1'b1);
    end

    // Pattern index counted from the top for most-significant-first order
    function automatic logic [spi_trig_pkg::PAT_IDX_W-1:0] PAT_IDX_W_SUB(
        input logic [spi_trig_pkg::PAT_IDX_W-1:0] len,
        input logic [spi_trig_pkg::PAT_IDX_W-1:0] at
    );
        PAT_IDX_W_SUB = len - 1'b1 - at;
    endfunction

    // Position, edge count and pattern comparison
    always_ff @(posedge link_clk or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            pos <= '0;
            edge_cnt <= '0;
            match_ok <= 1'b0;
            trig_tog <= 1'b0;
        end
        else if (in_frame)
        begin
            pos <= (k == spi_trig_pkg::PAT_IDX_W'(spi_trig_pkg::PAT_MAX)) ? k : k + 1'b1;
            edge_cnt <= fresh ? spi_trig_pkg::CNT_W'(1) : edge_cnt + 1'b1;
            // Only the bits inside the pattern are compared
            if (k < cfg_l.len)
            begin
                match_ok <= ok_now;
                // Fires only on the last bit, so a short frame never fires
                if (k == cfg_l.len - 1'b1 && ok_now)
                    trig_tog <= ~trig_tog;
            end
        end
    end

    // Word assembly on both data lines
    always_ff @(posedge link_clk or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            sh_miso <= '0;
            sh_mosi <= '0;
            word_l <= '0;
            wcnt <= '0;
            wgray_l <= '0;
            wbit <= '0;
            partial <= 1'b0;
        end
        else if (in_frame)
        begin
            sh_miso <= place(sh_miso, wp, SPI_MISO_I, cfg_l.msb_first);
            sh_mosi <= place(sh_mosi, wp, SPI_MOSI_I, cfg_l.msb_first);
            if (wdone)
            begin
                word_l.miso <= place(sh_miso, wp, SPI_MISO_I, cfg_l.msb_first);
                word_l.mosi <= place(sh_mosi, wp, SPI_MOSI_I, cfg_l.msb_first);
                wcnt <= wcnt + 1'b1;
                wgray_l <= (wcnt + 1'b1) ^ ((wcnt + 1'b1) >> 1);
                wbit <= '0;
                partial <= 1'b0;
            end
            else
            begin
                wbit <= wp + 1'b1;
                partial <= 1'b1;
            end
        end
    end

    // Toggles gathered in one place so the carrier has a single driver
    assign evt_l = '{wgray: wgray_l, trig: trig_tog};

    // ------------------------------------------------------------
    // Reference domain: reports
    // ------------------------------------------------------------
    spi_trig_pkg::link_evt_t evt_s; // Synchronised bus-domain toggles
    spi_trig_pkg::link_evt_t evt_prev; // Toggles one cycle back
    logic [1:0] wgap; // Words completed since last look
    logic alias_seen; // A word was overrun in this frame
    logic [spi_trig_pkg::FNUM_W-1:0] frame_num; // Number of the current frame

    bit_sync #(.WIDTH($bits(spi_trig_pkg::link_evt_t))) u_evt_sync (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESET_N_I),
        .d_i(evt_l),
        .q_o(evt_s)
    );

    assign wgap = gray2bin(evt_s.wgray) - gray2bin(evt_prev.wgray);

    // Trigger pulse and word report; word held stable until the next one
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            evt_prev <= '0;
            TRIGGER_O <= 1'b0;
            WORD_VALID_O <= 1'b0;
            MISO_WORD_O <= '0;
            MOSI_WORD_O <= '0;
            WORD_FRAME_O <= '0;
        end
        else
        begin
            evt_prev <= evt_s;
            TRIGGER_O <= (evt_s.trig != evt_prev.trig);
            WORD_VALID_O <= (wgap != '0);
            if (wgap != '0)
            begin
                MISO_WORD_O <= word_l.miso;
                MOSI_WORD_O <= word_l.mosi;
                WORD_FRAME_O <= frame_num;
            end
        end
    end

    // Frame report; values of the bus domain are still since the clock stopped
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            alias_seen <= 1'b0;
            frame_num <= '0;
            FRAME_DONE_O <= 1'b0;
            FRAME_NUM_O <= '0;
            EDGE_COUNT_O <= '0;
            FRAME_UNKNOWN_O <= 1'b0;
            FRAME_ALIASED_O <= 1'b0;
        end
        else
        begin
            // Overrun wins over the end-of-frame clear
            if (wgap > 2'h1)
                alias_seen <= 1'b1;
            else if (end_evt)
                alias_seen <= 1'b0;
            FRAME_DONE_O <= end_evt && moved;
            if (end_evt && moved)
            begin
                frame_num <= frame_num + 1'b1;
                FRAME_NUM_O <= frame_num;
                EDGE_COUNT_O <= edge_cnt;
                FRAME_UNKNOWN_O <= partial || (sclk_s != idle_high);
                FRAME_ALIASED_O <= alias_seen || (wgap > 2'h1);
            end
        end
    end

    // Decode slot holding this protocol, always exactly one
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            SLOT_O <= spi_trig_pkg::SLOT_RESET;
        else if (SLOT_WR_I)
            SLOT_O <= SLOT_SEL_I ? spi_trig_pkg::SLOT_TWO : spi_trig_pkg::SLOT_ONE;
    end

endmodule

// file: tb/spi_bus_model.sv
// SPI master and slave pair driving the monitored bus.
// Assumes select active low, clock idle low, data latched on rising edges.
`timescale 1ns/100ps
module spi_bus_model (
    // Bus lines
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    output logic miso_o
);
    initial {sclk_o, cs_n_o, mosi_o, miso_o} = 4'h5;
    // Shifts n bits MSB first at 160 ns; with sel low the clock still runs while select stays inactive
    task automatic xfer(input logic [7:0] mo, input logic [7:0] mi, input int n, input logic sel);
        cs_n_o = !sel;
        #80;
        for (int i = 7; i > 7 - n; i--)
        begin
            mosi_o = mo[i];
            miso_o = mi[i];
            #80 sclk_o = 1'b1;
            #80 sclk_o = 1'b0;
        end
        #80 cs_n_o = 1'b1;
        // Released lines show the inverse of the last bit
        mosi_o = !mosi_o;
        miso_o = !miso_o;
    endtask
endmodule

// file: tb/spi_pattern_trigger_chk.sv
// Output checks for the SPI pattern trigger.
// Assumes it is bound onto spi_pattern_trigger.
`timescale 1ns/100ps
module spi_pattern_trigger_chk (
    // Watched ports
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic SPI_CS_I,
    input wire logic FRAME_BY_TIMEOUT_I,
    input wire logic CS_ACTIVE_HIGH_I,
    input wire logic SLOT_WR_I,
    input wire logic SLOT_SEL_I,
    input wire logic TRIGGER_O,
    input wire logic WORD_VALID_O,
    input wire logic [spi_trig_pkg::WORD_MAX-1:0] MOSI_WORD_O,
    input wire logic FRAME_DONE_O,
    input wire logic [spi_trig_pkg::FNUM_W-1:0] FRAME_NUM_O,
    input wire logic [spi_trig_pkg::CNT_W-1:0] EDGE_COUNT_O,
    input wire logic [1:0] SLOT_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // Select held inactive long enough for any trigger to have left
    sequence cs_off;
        (!FRAME_BY_TIMEOUT_I && (SPI_CS_I != CS_ACTIVE_HIGH_I)) [*8];
    endsequence
    AST_TRIG_ONE: assert property (TRIGGER_O |=> !TRIGGER_O) else $error("long trigger");
    AST_WORD_ONE: assert property (WORD_VALID_O |=> !WORD_VALID_O) else $error("long word");
    AST_DONE_ONE: assert property (FRAME_DONE_O |=> !FRAME_DONE_O) else $error("long done");
    AST_SLOT_SET: assert property (SLOT_WR_I |=> SLOT_O == ($past(SLOT_SEL_I) ? 2'h2 : 2'h1))
        else $error("slot wrong");
    AST_NUM_HOLD: assert property ($changed(FRAME_NUM_O) |-> FRAME_DONE_O) else $error("num");
    AST_EDGE_HOLD: assert property ($changed(EDGE_COUNT_O) |-> FRAME_DONE_O) else $error("edge");
    AST_WORD_HOLD: assert property ($changed(MOSI_WORD_O) |-> WORD_VALID_O) else $error("word");
    AST_CS_QUIET: assert property (cs_off |-> !TRIGGER_O) else $error("trigger unselected");
endmodule
bind spi_pattern_trigger spi_pattern_trigger_chk chk (.REF_CLK_I, .RESET_N_I, .SPI_CS_I,
    .FRAME_BY_TIMEOUT_I, .CS_ACTIVE_HIGH_I, .SLOT_WR_I, .SLOT_SEL_I, .TRIGGER_O, .WORD_VALID_O,
    .MOSI_WORD_O, .FRAME_DONE_O, .FRAME_NUM_O, .EDGE_COUNT_O, .SLOT_O);

// file: tb/spi_bus_pattern_trigger_bench.sv
// Random frames compared with a reference model of the trigger and decoder.
// Assumes spi_bus_model on the bus and the checker bound in.
`timescale 1ns/100ps
module spi_bus_pattern_trigger_bench;
    logic clk = 1'b0, rst_n = 1'b0, sclk, cs_n, mosi, miso, trig, wv, done, unk, ali, msb = 1'b1;
    logic src = 1'b0, pat_wr = 1'b0, fill = 1'b0, slot_wr = 1'b0, slot_sel = 1'b0;
    logic [6:0] idx = 7'h00, plen = 7'h04;
    logic [1:0] code = 2'h0, slot;
    logic [23:0] lim = 24'h00000A;
    logic [5:0] dlen = 6'h08;
    logic [31:0] miso_w, mosi_w;
    logic [15:0] fnum, ecnt, wfr;
    logic [7:0] mo, mi, d, rmo, rmi;
    int failures = 0, total_checks = 0, seed = 32'hc56366c8, trigs, words, dones, n, hit, p[8];
    always #50 clk = !clk;
    // Count output pulses
    always @(posedge clk)
    begin
        trigs += trig;
        words += wv;
        dones += done;
    end
    spi_bus_model bus (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_o(miso));
    spi_pattern_trigger #(.IDLE_MAX_CYC(1000)) dut (.REF_CLK_I(clk), .RESET_N_I(rst_n),
        .SPI_SCLK_I(sclk), .SPI_CS_I(cs_n), .SPI_MOSI_I(mosi), .SPI_MISO_I(miso),
        .LATCH_FALL_I(1'b0), .FRAME_BY_TIMEOUT_I(1'b0), .CS_ACTIVE_HIGH_I(1'b0),
        .IDLE_LIMIT_I(lim), .IDLE_HIGH_I(1'b0), .MSB_FIRST_I(msb), .SRC_MOSI_I(src),
        .PAT_LEN_I(plen), .DEC_LEN_I(dlen), .PAT_WR_I(pat_wr), .PAT_FILL_I(fill),
        .PAT_IDX_I(idx), .PAT_CODE_I(code), .SLOT_WR_I(slot_wr), .SLOT_SEL_I(slot_sel),
        .TRIGGER_O(trig), .WORD_VALID_O(wv), .MISO_WORD_O(miso_w), .MOSI_WORD_O(mosi_w),
        .WORD_FRAME_O(wfr), .FRAME_DONE_O(done), .FRAME_NUM_O(fnum), .EDGE_COUNT_O(ecnt),
        .FRAME_UNKNOWN_O(unk), .FRAME_ALIASED_O(ali), .SLOT_O(slot));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (e !== g)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Pattern write or fill, one cycle wide
    task automatic wr(input logic f, input int i, input logic [1:0] c);
        @(posedge clk);
        fill <= f;
        pat_wr <= !f;
        idx <= i[6:0];
        code <= c;
        @(posedge clk);
        fill <= 1'b0;
        pat_wr <= 1'b0;
    endtask
    task automatic summarize();
        if (failures == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #500us;
        failures++;
        summarize();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("slot", 2, slot);
        for (int s = 0; s < 2; s++)
        begin
            slot_sel <= s[0];
            slot_wr <= 1'b1;
            @(posedge clk);
            slot_wr <= 1'b0;
            @(posedge clk);
            chk("slot", s + 1, slot);
        end
        for (int k = 0; k < 16; k++)
        begin
            n = (k % 4 == 3) ? 3 : 8;
            mo = 8'($random(seed));
            mi = 8'($random(seed));
            src <= k[0];
            msb <= k[1];
            plen <= 7'(4 + k % 5);
            lim <= 24'($random(seed));
            hit = $unsigned($random(seed)) % 3;
            wr(1'b1, 0, hit[1:0]);
            for (int i = 0; i < 8; i++)
            begin
                p[i] = k[0] ? hit : $unsigned($random(seed)) % 3;
                if (!k[0]) wr(1'b0, i, p[i][1:0]);
            end
            repeat (4) @(posedge clk);
            bus.xfer(mo, mi, 2, 1'b0);
            {trigs, words, dones} = 0;
            bus.xfer(mo, mi, n, 1'b1);
            repeat (12) @(posedge clk);
            d = src ? mo : mi;
            hit = n >= plen;
            for (int i = 0; i < plen; i++)
                if (p[i] != 2 && p[i] != d[7 - (msb ? plen - 1 - i : i)]) hit = 0;
            rmo = {<<{mo}};
            rmi = {<<{mi}};
            chk("trigger", hit, trigs);
            chk("frames", 1, dones);
            chk("number", k, fnum);
            chk("edges", n, ecnt);
            chk("unknown", n != 8, unk);
            chk("aliased", 0, ali);
            chk("words", n == 8, words);
            if (n == 8) chk("mosi", msb ? mo : rmo, mosi_w[7:0]);
            if (n == 8) chk("miso", msb ? mi : rmi, miso_w[7:0]);
            if (n == 8) chk("word frame", k, wfr);
        end
        summarize();
    end
endmodule
